// File: core/gder_map.svh
// Register indices, field positions, reset values and valid-bit masks
`ifndef GDER_MAP_SVH
`define GDER_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define GDER_IDX_GSTAT 6'h03
`define GDER_IDX_DIRL  6'h04
`define GDER_IDX_DIRH  6'h05
`define GDER_IDX_IML   6'h08
`define GDER_IDX_IMH   6'h09
`define GDER_IDX_ISL   6'h0A
`define GDER_IDX_ISH   6'h0B
`define GDER_IDX_CMD   6'h0C
`define GDER_IDX_DST   6'h0E
`define GDER_IDX_DMSK  6'h0F
`define GDER_IDX_CTRL  6'h20
`define GDER_IDX_RXSA  6'h21
`define GDER_IDX_RXSB  6'h22
`define GDER_IDX_TXCA  6'h23
`define GDER_IDX_TXCB  6'h24

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GDER_RST_DIR   16'hFF07
`define GDER_RST_PMSK  16'hFF07
`define GDER_RST_DMSK  8'h77
`define GDER_RST_CTRL  8'h01

// ----------------------------------------------------------------
// Implemented bits and field positions
// ----------------------------------------------------------------
`define GDER_PIN_VALID 16'h4707
`define GDER_DMA_VALID 8'h77
`define GDER_CMD_VALID 8'hAA
`define GDER_GSTAT_PIN 7
`define GDER_GSTAT_DMA 6
`define GDER_CTRL_GIM  0
`define GDER_RXS_DIS   15
`define GDER_EV_TXEND  0
`define GDER_EV_RXEND  1
`define GDER_EV_RXFULL 2

`endif

// File: core/gder_pkg.sv
// Types shared by the global event register block
package gder_pkg;

    typedef enum logic [1:0] {
        GDER_RESP_OKAY   = 2'b00,
        GDER_RESP_SLVERR = 2'b10
    } gder_resp_t;

    typedef logic [15:0] gder_pinvec_t;

endpackage : gder_pkg

// File: core/gder_pin_edge.sv
// Pin synchroniser and level-change detector
`timescale 1ns/1ps
`include "gder_map.svh"

module gder_pin_edge
    import gder_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // Asynchronous pins
    input  wire logic [WIDTH-1:0] pins_i,
    // Detected changes, one-cycle pulses
    output logic      [WIDTH-1:0] change_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;
    logic [WIDTH-1:0] change_q;
    logic [1:0]       fill_q;
    wire              armed = (fill_q == 2'h3);

    // R20 sync then compare
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_q   <= '0;
            sync_q   <= '0;
            last_q   <= '0;
            change_q <= '0;
            fill_q   <= 2'h0;
        end else begin
            meta_q   <= pins_i;
            sync_q   <= meta_q;
            last_q   <= sync_q;
            // No change reported until the chain holds real pin levels
            change_q <= armed ? (sync_q ^ last_q) : '0;
            if (!armed) begin
                fill_q <= fill_q + 2'h1;
            end
        end
    end

    assign change_o = change_q;

endmodule : gder_pin_edge

// File: core/gder_regs.sv
// Global pin and DMA event registers with AXI4-Lite slave
// What this block does
// R1: Unmasked input pin raises an event on every level change.
// R2: Pin mask bit one suppresses events; masks reset to one.
// R3: Pin status in two read-only bytes at fixed bit positions, reset zero.
// R4: Pin status bit set on change, held until software reads it.
// R5: Reading a pin status byte clears the bits it returned.
// R6: DMA command byte: tx B bit7, rx B bit5, tx A bit3, rx A bit1.
// R7: Writing one resets that DMA support logic; bit clears itself.
// R8: Writing zero to a command bit does nothing.
// R9: DMA status byte read-only: B events bits 6..4, A bits 2..0.
// R10: DMA events recorded while masked, shown once unmasked.
// R11: Receive reaching programmed buffer size raises buffer-full event.
// R12: Size-check disable bit suppresses the receive buffer length check.
// R13: Receive transfer end event when receive DMA transfer finished.
// R14: Transmit end event when programmed byte count moved to FIFO.
// R15: DMA mask byte mirrors status positions, resets to all masked.
// R16: DMA mask bit one keeps that event from the interrupt.
// R17: Global status bit7 any pin event, bit6 any unmasked DMA event.
// R18: Interrupt active while unmasked event pending and global mask clear.
// R19: Reading DMA status clears the events it returned.
// R20: Pins synchronised before change detection, one event per change.
`timescale 1ns/1ps
`include "gder_map.svh"

module gder_regs
    import gder_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W  = 16
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // General pins
    input  wire logic [10:0]       general_pins_i,
    // DMA progress, index 0 channel A, 1 channel B
    input  wire logic [1:0]        rx_byte_i,
    input  wire logic [1:0]        rx_done_i,
    input  wire logic [1:0]        tx_byte_i,
    // DMA support resets {tx_b, rx_b, tx_a, rx_a}
    output logic [3:0]             dma_reset_o,
    // Interrupt, active high
    output logic                   irq_o
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx == `GDER_IDX_GSTAT) || (idx == `GDER_IDX_DIRL)
                 || (idx == `GDER_IDX_DIRH) || (idx == `GDER_IDX_IML)
                 || (idx == `GDER_IDX_IMH) || (idx == `GDER_IDX_ISL)
                 || (idx == `GDER_IDX_ISH) || (idx == `GDER_IDX_CMD)
                 || (idx == `GDER_IDX_DST) || (idx == `GDER_IDX_DMSK)
                 || ((idx >= `GDER_IDX_CTRL) && (idx <= `GDER_IDX_TXCB));
    endfunction : is_mapped

    logic              aw_have_q;
    logic              w_have_q;
    logic [5:0]        aw_idx_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    gder_resp_t        bresp_q;
    logic              rvalid_q;
    gder_resp_t        rresp_q;
    logic [31:0]       rdata_q;

    wire         aw_go  = s_axi_awvalid && s_axi_awready;
    wire         w_go   = s_axi_wvalid && s_axi_wready;
    wire         wr_go  = aw_have_q && w_have_q && !bvalid_q;
    wire         rd_go  = s_axi_arvalid && s_axi_arready;
    wire [5:0]   ar_idx = s_axi_araddr[7:2];
    wire         wr_b0  = wr_go && wstrb_q[0];
    wire         wr_b1  = wr_go && wstrb_q[1];
    wire [7:0]   wbyte  = wdata_q[7:0];

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    gder_pinvec_t pin_dir_q;
    gder_pinvec_t pin_irq_mask_q;
    gder_pinvec_t pin_irq_pending_q;
    logic [7:0]   dma_reset_command_q;
    logic [7:0]   dma_event_status_q;
    logic [7:0]   dma_event_mask_q;
    logic [7:0]   ctrl_q;
    logic [15:0]  rx_size_q [2];
    logic [15:0]  tx_count_q [2];
    logic         irq_q;

    // Pin vector laid out as {high byte, low byte}
    gder_pinvec_t pin_change;
    gder_pin_edge #(.WIDTH(16)) u_edge (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .pins_i   ({general_pins_i[7:0], 5'h00, general_pins_i[10:8]}),
        .change_o (pin_change)
    );

    // R1 R2 unmasked inputs only
    wire [15:0] pin_set = pin_change & pin_dir_q & ~pin_irq_mask_q & `GDER_PIN_VALID;

    // ----------------------------------------------------------------
    // DMA event sources, per channel
    // ----------------------------------------------------------------
    logic [7:0] dma_set;
    logic [1:0] rx_rst;
    logic [1:0] tx_rst;
    assign rx_rst = {dma_reset_command_q[5], dma_reset_command_q[1]};
    assign tx_rst = {dma_reset_command_q[7], dma_reset_command_q[3]};

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            logic [CNT_W-1:0] rx_cnt_q;
            logic [CNT_W-1:0] tx_cnt_q;
            wire [CNT_W-1:0]  rx_next = rx_cnt_q + 1'b1;
            wire [CNT_W-1:0]  tx_next = tx_cnt_q + 1'b1;
            wire [14:0]       rx_lim  = rx_size_q[c][14:0];
            // R11 R12 length check unless disabled
            wire rx_full = rx_byte_i[c] && (rx_lim != 15'h0000)
                        && !rx_size_q[c][`GDER_RXS_DIS]
                        && (rx_next[14:0] == rx_lim);
            // R14 programmed count reached
            wire tx_end  = tx_byte_i[c] && (tx_count_q[c] != 16'h0000)
                        && (tx_next == tx_count_q[c]);
            // R13 transfer end from DMA side
            assign dma_set[4*c + `GDER_EV_RXEND]  = rx_done_i[c];
            assign dma_set[4*c + `GDER_EV_RXFULL] = rx_full;
            assign dma_set[4*c + `GDER_EV_TXEND]  = tx_end;
            assign dma_set[4*c + 3]               = 1'b0;

            always_ff @(posedge clock_i) begin
                if (!rst_n_i || rx_rst[c] || rx_done_i[c]) begin
                    rx_cnt_q <= '0;
                end else if (rx_byte_i[c]) begin
                    rx_cnt_q <= rx_next;
                end
            end

            always_ff @(posedge clock_i) begin
                if (!rst_n_i || tx_rst[c] || tx_end) begin
                    tx_cnt_q <= '0;
                end else if (tx_byte_i[c]) begin
                    tx_cnt_q <= tx_next;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire        any_pin = |pin_irq_pending_q;
    wire [7:0]  dma_vis = dma_event_status_q & ~dma_event_mask_q;
    wire        any_dma = |dma_vis;
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (ar_idx == `GDER_IDX_GSTAT) begin
            // R17 summary bits
            rd_val[`GDER_GSTAT_PIN] = any_pin;
            rd_val[`GDER_GSTAT_DMA] = any_dma;
        end else if (ar_idx == `GDER_IDX_DIRL) begin
            rd_val[7:0] = pin_dir_q[7:0];
        end else if (ar_idx == `GDER_IDX_DIRH) begin
            rd_val[7:0] = pin_dir_q[15:8];
        end else if (ar_idx == `GDER_IDX_IML) begin
            rd_val[7:0] = pin_irq_mask_q[7:0];
        end else if (ar_idx == `GDER_IDX_IMH) begin
            rd_val[7:0] = pin_irq_mask_q[15:8];
        end else if (ar_idx == `GDER_IDX_ISL) begin
            // R3 low byte
            rd_val[7:0] = pin_irq_pending_q[7:0];
        end else if (ar_idx == `GDER_IDX_ISH) begin
            rd_val[7:0] = pin_irq_pending_q[15:8];
        end else if (ar_idx == `GDER_IDX_CMD) begin
            rd_val[7:0] = dma_reset_command_q;
        end else if (ar_idx == `GDER_IDX_DST) begin
            // R9 raw record
            rd_val[7:0] = dma_event_status_q;
        end else if (ar_idx == `GDER_IDX_DMSK) begin
            rd_val[7:0] = dma_event_mask_q;
        end else if (ar_idx == `GDER_IDX_CTRL) begin
            rd_val[7:0] = ctrl_q;
        end else if (ar_idx == `GDER_IDX_RXSA) begin
            rd_val[15:0] = rx_size_q[0];
        end else if (ar_idx == `GDER_IDX_RXSB) begin
            rd_val[15:0] = rx_size_q[1];
        end else if (ar_idx == `GDER_IDX_TXCA) begin
            rd_val[15:0] = tx_count_q[0];
        end else if (ar_idx == `GDER_IDX_TXCB) begin
            rd_val[15:0] = tx_count_q[1];
        end
    end

    // R5 R19 clear only what the read returned
    wire        rd_isl  = rd_go && (ar_idx == `GDER_IDX_ISL);
    wire        rd_ish  = rd_go && (ar_idx == `GDER_IDX_ISH);
    wire        rd_dst  = rd_go && (ar_idx == `GDER_IDX_DST);
    wire [15:0] pin_clr = {rd_ish ? rd_val[7:0] : 8'h00, rd_isl ? rd_val[7:0] : 8'h00};
    wire [7:0]  dma_clr = rd_dst ? rd_val[7:0] : 8'h00;

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_idx_q  <= 6'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= GDER_RESP_OKAY;
        end else begin
            if (aw_go) begin
                aw_have_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[7:2];
            end
            if (w_go) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= is_mapped(aw_idx_q) ? GDER_RESP_OKAY : GDER_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rresp_q  <= GDER_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= is_mapped(ar_idx) ? GDER_RESP_OKAY : GDER_RESP_SLVERR;
            rdata_q  <= rd_val;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

    // ----------------------------------------------------------------
    // Register writes and event flags
    // ----------------------------------------------------------------
    wire wr_dirl = wr_b0 && (aw_idx_q == `GDER_IDX_DIRL);
    wire wr_dirh = wr_b0 && (aw_idx_q == `GDER_IDX_DIRH);
    wire wr_iml  = wr_b0 && (aw_idx_q == `GDER_IDX_IML);
    wire wr_imh  = wr_b0 && (aw_idx_q == `GDER_IDX_IMH);
    wire wr_cmd  = wr_b0 && (aw_idx_q == `GDER_IDX_CMD);
    wire wr_dmsk = wr_b0 && (aw_idx_q == `GDER_IDX_DMSK);
    wire wr_ctrl = wr_b0 && (aw_idx_q == `GDER_IDX_CTRL);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_dir_q      <= `GDER_RST_DIR;
            // R2 masks start set
            pin_irq_mask_q <= `GDER_RST_PMSK;
            ctrl_q         <= `GDER_RST_CTRL;
            // R15 all DMA events masked
            dma_event_mask_q <= `GDER_RST_DMSK;
        end else begin
            // Unimplemented bits keep their fixed values
            if (wr_dirl) pin_dir_q[7:0]  <= wbyte & 8'h07;
            if (wr_dirh) pin_dir_q[15:8] <= wbyte | 8'hB8;
            if (wr_iml)  pin_irq_mask_q[7:0]  <= (wbyte & 8'h07);
            if (wr_imh)  pin_irq_mask_q[15:8] <= wbyte | 8'hB8;
            if (wr_dmsk) dma_event_mask_q <= wbyte & `GDER_DMA_VALID;
            if (wr_ctrl) ctrl_q <= {7'h00, wbyte[`GDER_CTRL_GIM]};
        end
    end

    generate
        for (c = 0; c < 2; c++) begin : g_cfg
            wire [5:0] rxs_idx = (c == 0) ? `GDER_IDX_RXSA : `GDER_IDX_RXSB;
            wire [5:0] txc_idx = (c == 0) ? `GDER_IDX_TXCA : `GDER_IDX_TXCB;
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    rx_size_q[c]  <= 16'h0000;
                    tx_count_q[c] <= 16'h0000;
                end else begin
                    if (wr_b0 && aw_idx_q == rxs_idx) rx_size_q[c][7:0]   <= wbyte;
                    if (wr_b1 && aw_idx_q == rxs_idx) rx_size_q[c][15:8]  <= wdata_q[15:8];
                    if (wr_b0 && aw_idx_q == txc_idx) tx_count_q[c][7:0]  <= wbyte;
                    if (wr_b1 && aw_idx_q == txc_idx) tx_count_q[c][15:8] <= wdata_q[15:8];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_irq_pending_q   <= 16'h0000;
            dma_event_status_q  <= 8'h00;
            dma_reset_command_q <= 8'h00;
            irq_q               <= 1'b0;
        end else begin
            // R4 R5 set wins over read clear
            pin_irq_pending_q  <= (pin_irq_pending_q & ~pin_clr) | pin_set;
            // R10 R19 recorded regardless of mask
            dma_event_status_q <= ((dma_event_status_q & ~dma_clr) | dma_set) & `GDER_DMA_VALID;
            // R6 R7 R8 one-cycle command, ones only
            dma_reset_command_q <= wr_cmd ? (wbyte & `GDER_CMD_VALID) : 8'h00;
            // R16 R18 masked events stay quiet
            irq_q <= !ctrl_q[`GDER_CTRL_GIM] && (any_pin || any_dma);
        end
    end

    assign dma_reset_o = {dma_reset_command_q[7], dma_reset_command_q[5],
                          dma_reset_command_q[3], dma_reset_command_q[1]};
    assign irq_o       = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_pin_set;
        (pin_set != 16'h0000) |=> ((pin_irq_pending_q & $past(pin_set)) == $past(pin_set));
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin change not recorded"); // R1

    property p_pin_mask;
        ##1 ((pin_irq_pending_q & ~$past(pin_irq_pending_q) & $past(pin_irq_mask_q)) == 16'h0);
    endproperty
    a_pin_mask: assert property (p_pin_mask) else $error("masked pin raised status"); // R2

    property p_pin_hold;
        !(rd_isl || rd_ish) |=> ((pin_irq_pending_q & $past(pin_irq_pending_q))
                                 == $past(pin_irq_pending_q));
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin status lost"); // R4

    property p_pin_rdclr;
        (rd_isl && pin_set[7:0] == 8'h00) |=> (pin_irq_pending_q[7:0] == 8'h00);
    endproperty
    a_pin_rdclr: assert property (p_pin_rdclr) else $error("pin read did not clear"); // R5

    property p_cmd_self;
        (wr_cmd && wbyte[3]) |=> dma_reset_o[1] ##1 (dma_reset_o == 4'h0);
    endproperty
    a_cmd_self: assert property (p_cmd_self) else $error("reset pulse wrong"); // R7

    property p_cmd_zero;
        (wr_cmd && (wbyte & `GDER_CMD_VALID) == 8'h00) |=> (dma_reset_o == 4'h0);
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("zero write reset DMA"); // R8

    property p_dma_rec;
        (dma_set != 8'h00) |=> ((dma_event_status_q & $past(dma_set)) == $past(dma_set));
    endproperty
    a_dma_rec: assert property (p_dma_rec) else $error("DMA event not recorded"); // R10

    property p_rx_dis;
        rx_size_q[0][`GDER_RXS_DIS] |-> !dma_set[`GDER_EV_RXFULL];
    endproperty
    a_rx_dis: assert property (p_rx_dis) else $error("disabled size check fired"); // R12

    property p_dma_mask;
        (!any_pin && dma_vis == 8'h00) [*2] |-> !irq_o;
    endproperty
    a_dma_mask: assert property (p_dma_mask) else $error("masked DMA event raised irq"); // R16

    property p_irq;
        (!ctrl_q[`GDER_CTRL_GIM] && any_pin) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // R18

    property p_dma_rdclr;
        (rd_dst && dma_set == 8'h00) |=> (dma_event_status_q == 8'h00);
    endproperty
    a_dma_rdclr: assert property (p_dma_rdclr) else $error("DMA read did not clear"); // R19

    c_pin_irq:  cover property (pin_set != 16'h0000 ##[1:4] irq_o);
    c_dma_read: cover property (rd_dst && dma_event_status_q != 8'h00);
    c_rx_full:  cover property (dma_set[`GDER_EV_RXFULL]);
    c_reset:    cover property (dma_reset_o != 4'h0);

endmodule : gder_regs

// File: testbench/gder_dma_model.sv
// Model of the DMA engine that feeds byte and done pulses
`timescale 1ns/1ps
module gder_dma_model (
    // Clock and request
    input  wire logic       clock_i,
    input  wire logic       go_i,
    input  wire logic [1:0] kind_i,
    input  wire logic       ch_i,
    input  wire logic [3:0] n_i,
    // Pulses to the event block, and busy while pulses run
    output logic [1:0]      rx_byte_o,
    output logic [1:0]      rx_done_o,
    output logic [1:0]      tx_byte_o,
    output logic            busy_o
);
    logic [3:0] left_q = 4'h0;
    logic [1:0] kind_q = 2'h0;
    logic       ch_q   = 1'h0;
    logic [1:0] sel;
    // Back-to-back pulses, the fastest a real engine could move bytes
    always @(posedge clock_i) begin
        if (go_i) begin
            left_q <= n_i;
            kind_q <= kind_i;
            ch_q   <= ch_i;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end
    assign busy_o    = (left_q != 4'h0);
    assign sel       = busy_o ? (2'h1 << ch_q) : 2'h0;
    assign rx_byte_o = (kind_q == 2'h0) ? sel : 2'h0;
    assign tx_byte_o = (kind_q == 2'h1) ? sel : 2'h0;
    assign rx_done_o = (kind_q == 2'h2) ? sel : 2'h0;
endmodule : gder_dma_model

// File: testbench/gder_regs_tb_top.sv
// Register-level bench for the global event register block
`timescale 1ns/1ps
module gder_regs_tb_top;
    import gder_pkg::*;
    logic        clock_i = 1'h0, rst_n_i = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, busy, go = 1'h0, ch = 1'h0;
    logic [1:0]  bresp, rresp, kind = 2'h0, rxb, rxd, txb;
    logic [3:0]  n = 4'h0, rst_o, rst_seen = 4'h0;
    logic [10:0] pins = 11'h000;
    int          fail_count = 0, checked = 0, cyc = 0, pulses = 0;
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (rst_o != 4'h0) begin
            rst_seen <= rst_o;
            pulses++;
        end
        if (++cyc == 6000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    gder_regs uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .general_pins_i(pins), .rx_byte_i(rxb),
        .rx_done_i(rxd), .tx_byte_i(txb), .dma_reset_o(rst_o), .irq_o(irq));
    gder_dma_model dma_far (.clock_i(clock_i), .go_i(go), .kind_i(kind), .ch_i(ch),
        .n_i(n), .rx_byte_o(rxb), .rx_done_o(rxd), .tx_byte_o(txb), .busy_o(busy));
    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
        do begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'h0;
        chk($sformatf("reg %h", a), d, exp);
    endtask : rd
    task automatic dma(input logic [1:0] k, input logic c, input logic [3:0] m);
        @(posedge clock_i);
        {go, kind, ch, n} <= {1'h1, k, c, m};
        @(posedge clock_i);
        go <= 1'h0;
        do @(posedge clock_i); while (busy);
        repeat (3) @(posedge clock_i);
    endtask : dma
    initial begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'h1;
        rd(8'h28, 32'h0);
        rd(8'h2C, 32'h0);
        rd(8'h30, 32'h0);
        rd(8'h38, 32'h0);
        rd(8'h3C, 32'h77);
        rd(8'h24, 32'hFF);
        rd(8'h20, 32'h07);
        rd(8'hFC, 32'h0);
        chk("rresp", {30'h0, rresp}, 32'h2);
        wr(8'hFC, 32'h0);
        chk("bresp", {30'h0, bresp}, 32'h2);
        wr(8'h80, 32'h0);
        wr(8'h24, 32'hFE);
        wr(8'h20, 32'h05);
        @(posedge clock_i);
        pins <= 11'h203;
        repeat (10) @(posedge clock_i);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(8'h0C, 32'h80);
        rd(8'h2C, 32'h01);
        rd(8'h28, 32'h02);
        repeat (2) @(posedge clock_i);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(8'h2C, 32'h0);
        pins <= 11'h000;
        repeat (10) @(posedge clock_i);
        rd(8'h2C, 32'h01);
        rd(8'h28, 32'h02);
        rd(8'h2C, 32'h0);
        wr(8'h30, 32'hAA);
        repeat (2) @(posedge clock_i);
        chk("dma reset", {28'h0, rst_seen}, 32'hF);
        rd(8'h30, 32'h0);
        wr(8'h30, 32'h0);
        repeat (2) @(posedge clock_i);
        chk("pulses", pulses, 32'h1);
        wr(8'h30, 32'h08);
        repeat (2) @(posedge clock_i);
        chk("dma reset", {28'h0, rst_seen}, 32'h2);
        wr(8'h8C, 32'h3);
        dma(2'h1, 1'h0, 4'h3);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(8'h0C, 32'h0);
        wr(8'h3C, 32'h76);
        repeat (2) @(posedge clock_i);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(8'h3C, 32'h76);
        rd(8'h0C, 32'h40);
        rd(8'h38, 32'h01);
        repeat (2) @(posedge clock_i);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(8'h38, 32'h0);
        wr(8'h88, 32'h2);
        dma(2'h0, 1'h1, 4'h2);
        rd(8'h38, 32'h40);
        dma(2'h2, 1'h0, 4'h1);
        rd(8'h38, 32'h02);
        wr(8'h84, 32'h8002);
        dma(2'h0, 1'h0, 4'h2);
        rd(8'h38, 32'h0);
        tally_and_finish();
    end
endmodule : gder_regs_tb_top
